// ===== include/sco_pkg.sv
// Package: constants for the serial configuration link and output control
package sco_pkg;
  localparam int ADDR_W      = 3;
  localparam int DATA_W      = 11;
  localparam int FRAME_BITS  = 15;
  localparam int CNT_W       = 4;
  localparam logic DIR_READ  = 1'h1;
  localparam logic DIR_WRITE = 1'h0;
  localparam logic [ADDR_W-1:0] ROUTE_ADDR = 3'h6;
  localparam logic [DATA_W-1:0] ROUTE_RESET = 11'h047;
  localparam int BIT_ROUTE_A = 3;
  localparam int BIT_ROUTE_B = 4;
  localparam int BIT_ROUTE_C = 5;
  localparam int BIT_ROUTE_D = 6;
  localparam int BIT_HOLD    = 7;
  localparam int BIT_TEST    = 8;
  localparam int BIT_TCLK    = 9;
  localparam int BIT_EXTERNAL_REFERENCE_SELECT  = 10;
  localparam int DIV_W       = 2;
  localparam logic [DIV_W-1:0] PH_0   = 2'h0;
  localparam logic [DIV_W-1:0] PH_90  = 2'h1;
  localparam logic [DIV_W-1:0] PH_180 = 2'h2;
  localparam logic [DIV_W-1:0] PH_270 = 2'h3;
  localparam logic [CNT_W-1:0] SCLK_HALF = 4'h4;
  typedef enum logic [1:0] {
    SCO_IDLE,
    SCO_SHIFT,
    SCO_LOAD
  } sco_state_e;
endpackage

// ===== include/sco_if.sv
// Interface: three-wire serial programming link
`timescale 1ns/1ps
interface sco_if;
  logic serial_select_n;
  logic sclk;
  logic host_data_o;
  logic host_data_oe;
  logic dev_data_o;
  logic dev_data_oe;
  logic serial_data;
  assign serial_data = dev_data_oe ? dev_data_o :
                       host_data_oe ? host_data_o : 1'b1;
  modport host (
    output serial_select_n,
    output sclk,
    output host_data_o,
    output host_data_oe,
    input  serial_data
  );
  modport device (
    input  serial_select_n,
    input  sclk,
    output dev_data_o,
    output dev_data_oe,
    input  serial_data
  );
endinterface

// ===== src/sco_out_mux.sv
// Output router: auxiliary output selection and differential clock gating
`timescale 1ns/1ps
module sco_out_mux
  import sco_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic [DATA_W-1:0]     ctrl,
  input  wire logic                  synth_clk,
  input  wire logic                  load_cnt,
  input  wire logic                  fbk_pulse,
  input  wire logic                  sync_lo,
  input  wire logic                  sync_hi,
  output logic                       clk_p,
  output logic                       clk_n,
  output logic [3:0]                 aux_out
);
  // ----------------------------------------------------------------
  // Divide-by-four phases and hold release
  // ----------------------------------------------------------------
  logic [DIV_W-1:0] div_reg;
  logic             run_reg;
  logic             load_q_reg;
  logic             synth_q_reg;
  logic [3:0]       div_ph;
  logic [3:0]       route_sel;
  logic [3:0]       normal_src;
  logic [3:0]       aux_next;
  logic             load_rise;
  logic             diff_next;
  logic             hold;
  logic             test_en;

  assign hold      = ctrl[BIT_HOLD];
  assign test_en   = ctrl[BIT_TEST];
  assign load_rise = load_cnt & ~load_q_reg;
  assign route_sel = {ctrl[BIT_ROUTE_D], ctrl[BIT_ROUTE_C],
                      ctrl[BIT_ROUTE_B], ctrl[BIT_ROUTE_A]};
  // Each phase is high for two of the four counts: a square wave at a
  // quarter of the synthesized rate
  assign div_ph    = {(div_reg == PH_270) | (div_reg == PH_0),
                      (div_reg == PH_180) | (div_reg == PH_270),
                      (div_reg == PH_90)  | (div_reg == PH_180),
                      (div_reg == PH_0)   | (div_reg == PH_90)};
  assign normal_src = {sync_hi, sync_lo, fbk_pulse, load_cnt};

  // Restart is held off until a load counter rising edge, keeping the
  // resumed clock within one period of it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      run_reg    <= 1'b1;
      load_q_reg <= 1'b0;
      div_reg    <= PH_0;
      synth_q_reg <= 1'b0;
    end else begin
      load_q_reg  <= load_cnt;
      synth_q_reg <= synth_clk;
      if (hold)
        run_reg <= 1'b0;
      else if (load_rise)
        run_reg <= 1'b1;
      if (!run_reg)
        div_reg <= PH_0;
      else if (synth_clk & ~synth_q_reg)
        div_reg <= div_reg + 2'h1;
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_aux
      // Test mode turns each output into a static copy of its select
      assign aux_next[i] = test_en ? route_sel[i] :
                           route_sel[i] ? div_ph[i] : normal_src[i];
    end
  endgenerate

  assign diff_next = test_en ? ctrl[BIT_TCLK] :
                     (hold | ~run_reg) ? 1'b1 : synth_clk;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_p   <= 1'b1;
      clk_n   <= 1'b0;
      aux_out <= 4'h0;
    end else begin
      clk_p   <= diff_next;
      clk_n   <= ~diff_next;
      aux_out <= aux_next;
    end
  end
endmodule

// ===== src/sco_device.sv
// Device end: serial link slave and output control register
//
// The APB register port was decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Bit 3 routes output a, default 0
// - Bit 4 routes output b, default 0
// - Bit 5 routes output c, default 0
// - Bit 6 routes output d, default 1
// - Test mode: outputs follow their select bits
// - Test mode: differential pair follows bit 9
// - Outside test mode, hold bit forces true high, complement low
// - Release resumes aligned to load counter edge
// - Bit 10 selects crystal or external reference
// - First bit is direction: one reads
// - Address and data shifted LSB first
// - Sixteen rising edges, last loads select high
// - Select changes while serial clock same level
// - Read uses two transfers, device drives second
// - Three address bits then eleven data bits
module sco_device
  import sco_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  sco_if.device            LINK,
  input  wire logic        SYNTH_CLK,
  input  wire logic        LOAD_CNT,
  input  wire logic        FBK_PULSE,
  input  wire logic        SYNC_LO,
  input  wire logic        SYNC_HI,
  output logic             CLK_P,
  output logic             CLK_N,
  output logic             AUX_OUTPUT_A,
  output logic             AUX_OUTPUT_B,
  output logic             AUX_OUTPUT_C,
  output logic             AUX_OUTPUT_D,
  output logic             EXTERNAL_REFERENCE_SELECT
);
  // ----------------------------------------------------------------
  // Serial clock edge detection
  // ----------------------------------------------------------------
  // Link pins are sampled on REF_CLK; serial clock must stay well below
  // half the reference rate
  logic                  sclk_q_reg;
  logic                  sclk_rise;
  logic                  sclk_fall;
  logic [CNT_W-1:0]      cnt_reg;
  logic [FRAME_BITS-1:0] shift_reg;
  logic [DATA_W-1:0]     route_reg;
  logic                  rd_pend_reg;
  logic                  rd_act_reg;
  logic [DATA_W-1:0]     rd_data_reg;
  logic                  out_reg;
  logic                  oe_reg;
  logic                  load_edge;
  logic                  frame_full;
  logic                  dir;
  logic [ADDR_W-1:0]     addr;
  logic [DATA_W-1:0]     data;
  logic [3:0]            aux;
  sco_state_e            state_reg;
  logic                  shift_en;
  logic                  commit;
  logic                  frame_open;
  logic                  wr_hit;
  logic                  drive_bit;
  logic                  drive_stop;
  logic [CNT_W-1:0]      rd_idx;

  assign sclk_rise  = LINK.sclk & ~sclk_q_reg;
  assign sclk_fall  = ~LINK.sclk & sclk_q_reg;
  assign frame_full = cnt_reg == CNT_W'(FRAME_BITS);
  // Shift right: first bit ends lowest after the frame is full
  assign dir  = shift_reg[0];
  assign addr = shift_reg[ADDR_W:1];
  assign data = shift_reg[FRAME_BITS-1:ADDR_W+1];
  // Sixteenth rising edge, taken with select high, commits the frame
  assign load_edge = sclk_rise & LINK.serial_select_n
                     & frame_full;
  assign shift_en   = (state_reg == SCO_SHIFT) & sclk_rise
                      & ~LINK.serial_select_n & ~frame_full;
  assign commit     = (state_reg == SCO_LOAD) & load_edge;
  assign frame_open = (state_reg == SCO_IDLE) & ~LINK.serial_select_n;
  assign wr_hit     = commit & (dir == DIR_WRITE)
                      & (addr == ROUTE_ADDR);

  // ----------------------------------------------------------------
  // Frame shifter and register commit
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      sclk_q_reg <= 1'b0;
    else
      sclk_q_reg <= LINK.sclk;
  end

  // Counter clears between frames; stale shifter bits are harmless,
  // since only a full frame is ever decoded
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      cnt_reg   <= '0;
      shift_reg <= '0;
    end else if (state_reg == SCO_IDLE) begin
      cnt_reg   <= '0;
    end else if (shift_en) begin
      shift_reg <= {LINK.serial_data, shift_reg[FRAME_BITS-1:1]};
      cnt_reg   <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg <= SCO_IDLE;
    end else begin
      unique case (state_reg)
        SCO_IDLE: begin
          if (!LINK.serial_select_n)
            state_reg <= SCO_SHIFT;
        end
        SCO_SHIFT: begin
          // Select rising ends the data bits of the frame
          if (LINK.serial_select_n)
            state_reg <= SCO_LOAD;
        end
        SCO_LOAD: begin
          // A short frame drops here with nothing stored
          if (load_edge || !frame_full || !LINK.serial_select_n)
            state_reg <= SCO_IDLE;
        end
        default: state_reg <= SCO_IDLE;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      route_reg   <= ROUTE_RESET;
      rd_pend_reg <= 1'b0;
      rd_data_reg <= '0;
    end else if (commit) begin
      if (wr_hit)
        route_reg <= data;
      // The answer frame reads as a read too; it must not arm another
      rd_pend_reg <= (dir == DIR_READ) & ~rd_act_reg;
      rd_data_reg <= (addr == ROUTE_ADDR) ? route_reg : '0;
    end
  end

  // ----------------------------------------------------------------
  // Read return: second transfer, device drives data on falling edges
  // ----------------------------------------------------------------
  // Data bits occupy rising edges 5..15; present them one falling
  // edge early, LSB first
  assign rd_idx     = cnt_reg - CNT_W'(ADDR_W + 1);
  assign drive_bit  = rd_act_reg & sclk_fall & ~LINK.serial_select_n
                      & (cnt_reg >= CNT_W'(ADDR_W + 1)) & ~frame_full;
  assign drive_stop = ~rd_act_reg | LINK.serial_select_n | frame_full;

  // Armed by a read command, spent by the answer frame after it
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      rd_act_reg <= 1'b0;
    else if (commit)
      rd_act_reg <= 1'b0;
    else if (frame_open)
      rd_act_reg <= rd_pend_reg;
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else if (drive_bit) begin
      out_reg <= rd_data_reg[rd_idx];
      oe_reg  <= 1'b1;
    end else if (drive_stop) begin
      oe_reg  <= 1'b0;
    end
  end

  assign LINK.dev_data_o  = out_reg;
  assign LINK.dev_data_oe = oe_reg;

  // ----------------------------------------------------------------
  // Output control
  // ----------------------------------------------------------------
  sco_out_mux u_mux (
    .clk       (REF_CLK),
    .rst       (RESET),
    .ctrl      (route_reg),
    .synth_clk (SYNTH_CLK),
    .load_cnt  (LOAD_CNT),
    .fbk_pulse (FBK_PULSE),
    .sync_lo   (SYNC_LO),
    .sync_hi   (SYNC_HI),
    .clk_p     (CLK_P),
    .clk_n     (CLK_N),
    .aux_out   (aux)
  );

  assign AUX_OUTPUT_A = aux[0];
  assign AUX_OUTPUT_B = aux[1];
  assign AUX_OUTPUT_C = aux[2];
  assign AUX_OUTPUT_D = aux[3];
  assign EXTERNAL_REFERENCE_SELECT = route_reg[BIT_EXTERNAL_REFERENCE_SELECT];
endmodule

// ===== src/sco_host.sv
// Host end: APB-driven serial link master
`timescale 1ns/1ps
module sco_host
  import sco_pkg::*;
(
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [3:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  sco_if.host              LINK
);
  // ----------------------------------------------------------------
  // Registers: 0x0 command (write starts), 0x4 status / read data
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_OFS  = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;
  localparam int         CMD_DIR  = 14;
  logic [FRAME_BITS-1:0] frame_reg;
  logic [DATA_W-1:0]     rd_reg;
  logic [4:0]            bit_reg;
  logic [CNT_W-1:0]      div_reg;
  logic                  busy_reg;
  logic                  second_reg;
  logic                  sclk_reg;
  logic                  sel_n_reg;
  logic                  acc;
  logic                  wr_cmd;
  logic                  tick;

  assign acc    = PSEL & PENABLE;
  assign wr_cmd = acc & PWRITE & (PADDR == CMD_OFS) & ~busy_reg;
  assign tick   = div_reg == SCLK_HALF;
  assign PREADY  = 1'b1;
  assign PSLVERR = acc & (PADDR != CMD_OFS) & (PADDR != STAT_OFS);
  assign PRDATA  = (PADDR == STAT_OFS) ?
                   {20'h0, busy_reg, rd_reg} : 32'h0;
  assign LINK.serial_select_n = sel_n_reg;
  assign LINK.sclk            = sclk_reg;
  assign LINK.host_data_o     = frame_reg[0];
  // Second half of a read leaves the line to the device
  assign LINK.host_data_oe    = ~sel_n_reg & ~second_reg;

  // ----------------------------------------------------------------
  // Frame engine: bit_reg counts rising edges 0..16
  // ----------------------------------------------------------------
  // Select is moved only while the serial clock is low
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      frame_reg  <= '0;
      rd_reg     <= '0;
      bit_reg    <= '0;
      div_reg    <= '0;
      busy_reg   <= 1'b0;
      second_reg <= 1'b0;
      sclk_reg   <= 1'b0;
      sel_n_reg  <= 1'b1;
    end else if (wr_cmd) begin
      // Direction in bit 0, address LSB first, then data LSB first
      frame_reg  <= {PWDATA[DATA_W-1:0], PWDATA[DATA_W+ADDR_W-1:DATA_W],
                     PWDATA[CMD_DIR]};
      busy_reg   <= 1'b1;
      second_reg <= 1'b0;
      bit_reg    <= '0;
      div_reg    <= '0;
      sel_n_reg  <= 1'b0;
    end else if (busy_reg) begin
      div_reg <= tick ? '0 : div_reg + 4'h1;
      if (tick) begin
        sclk_reg <= ~sclk_reg;
        if (!sclk_reg) begin
          bit_reg <= bit_reg + 5'h1;
          if (second_reg && bit_reg > 5'(ADDR_W) &&
              bit_reg < 5'(FRAME_BITS))
            rd_reg <= {LINK.serial_data, rd_reg[DATA_W-1:1]};
        end else begin
          frame_reg <= {1'b0, frame_reg[FRAME_BITS-1:1]};
          if (bit_reg == 5'(FRAME_BITS))
            sel_n_reg <= 1'b1;
          if (bit_reg == 5'(FRAME_BITS + 1)) begin
            bit_reg <= '0;
            if (second_reg || !rd_pending())
              busy_reg <= 1'b0;
            else begin
              second_reg <= 1'b1;
              sel_n_reg  <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Read command is remembered in the direction bit of the last command
  logic dir_reg;
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET)
      dir_reg <= DIR_WRITE;
    else if (wr_cmd)
      dir_reg <= PWDATA[CMD_DIR];
  end

  function automatic logic rd_pending();
    return dir_reg == DIR_READ;
  endfunction
endmodule

// ===== verif/sco_link_monitor.sv
// Checker: timing and framing of the serial link
`timescale 1ns/1ps
module sco_link_monitor (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic serial_select_n,
  input wire logic sclk,
  input wire logic host_data_o,
  input wire logic host_data_oe,
  input wire logic dev_data_o,
  input wire logic dev_data_oe,
  input wire logic serial_data
);
  // ------------------------------
  // Frame bookkeeping
  // ------------------------------
  logic       sclk_d;
  logic       sel_d;
  logic       sclk_rise;
  logic [4:0] rise_cnt;
  logic [4:0] rise_cnt_next;
  assign sclk_rise = sclk && !sclk_d && !serial_select_n;
  // Cleared as a frame opens, so a short frame shows at the close
  assign rise_cnt_next = (!serial_select_n && sel_d) ? 5'h00 :
                         sclk_rise ? rise_cnt + 5'h01 : rise_cnt;
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      sclk_d   <= 1'b0;
      sel_d    <= 1'b1;
      rise_cnt <= 5'h00;
    end else begin
      sclk_d   <= sclk;
      sel_d    <= serial_select_n;
      rise_cnt <= rise_cnt_next;
    end
  end
  // ------------------------------
  // Properties
  // ------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RESET);
  AST_SEL_FALL: assert property ($fell(serial_select_n) |-> !sclk)
    else $error("select fell with serial clock high");
  AST_SEL_RISE: assert property ($rose(serial_select_n) |-> !sclk)
    else $error("select rose with serial clock high");
  AST_ONE_DRIVER: assert property (!(host_data_oe && dev_data_oe))
    else $error("both ends drive the data line");
  AST_DEV_IDLE: assert property (
    serial_select_n && $past(serial_select_n) |-> !dev_data_oe)
    else $error("device drives data while deselected");
  AST_SCLK_MIN: assert property ($rose(sclk) |-> sclk[*4])
    else $error("serial clock high phase too short");
  AST_SCLK_MAX: assert property ($rose(sclk) |-> ##[4:6] !sclk)
    else $error("serial clock high phase too long");
  AST_FRAME_BITS: assert property (
    $rose(serial_select_n) |-> rise_cnt == 5'h0f)
    else $error("frame closed without fifteen rises");
  AST_LOAD_EDGE: assert property (
    $rose(serial_select_n) |-> ##[1:12] $rose(sclk))
    else $error("no load rise after select went high");
  AST_DEV_HDR: assert property (
    dev_data_oe |-> rise_cnt >= 5'h04)
    else $error("device drives before the header ended");
  AST_SETUP: assert property (
    $rose(sclk) && !serial_select_n |-> $stable(serial_data))
    else $error("data changed at a serial clock rise");
endmodule

// ===== verif/test_serial_config_output_control.sv
// Testbench: APB host end and device end joined over the link
`timescale 1ns/1ps
module test_serial_config_output_control;
  import sco_pkg::*;
  logic        ref_clk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [3:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        slv_err;
  logic        synth_clk;
  logic [3:0]  aux_in;
  logic [3:0]  aux;
  logic        clk_p;
  logic        clk_n;
  logic        ext_sel;
  logic        ext_sel_b;
  logic        tog;
  logic [31:0] q;
  logic [14:0] cap;
  logic [14:0] last_frame;
  logic [3:0]  cap_idx;
  logic [15:0] n_hi;
  logic        sclk_d;
  logic        sel_d;
  logic [10:0] tm [2] = '{11'h128, 11'h350};
  logic [3:0]  pat [2] = '{4'hb, 4'h4};
  int          errors;
  int          n_compared;
  int          cycles;
  sco_if link ();
  sco_if link_b ();
  sco_host u_sco_host (.REF_CLK(ref_clk), .RESET(reset), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .LINK(link));
  sco_device u_sco_device (.REF_CLK(ref_clk), .RESET(reset), .LINK(link),
    .SYNTH_CLK(synth_clk), .LOAD_CNT(aux_in[0]), .FBK_PULSE(aux_in[1]),
    .SYNC_LO(aux_in[2]), .SYNC_HI(aux_in[3]), .CLK_P(clk_p), .CLK_N(clk_n),
    .AUX_OUTPUT_A(aux[0]), .AUX_OUTPUT_B(aux[1]), .AUX_OUTPUT_C(aux[2]),
    .AUX_OUTPUT_D(aux[3]), .EXTERNAL_REFERENCE_SELECT(ext_sel));
  // Second device faces the bench directly, so frames can be broken
  sco_device u_sco_device_b (.REF_CLK(ref_clk), .RESET(reset),
    .LINK(link_b), .SYNTH_CLK(synth_clk), .LOAD_CNT(aux_in[0]),
    .FBK_PULSE(aux_in[1]), .SYNC_LO(aux_in[2]), .SYNC_HI(aux_in[3]),
    .CLK_P(), .CLK_N(), .AUX_OUTPUT_A(), .AUX_OUTPUT_B(), .AUX_OUTPUT_C(),
    .AUX_OUTPUT_D(), .EXTERNAL_REFERENCE_SELECT(ext_sel_b));
  sco_link_monitor u_sco_link_monitor (.REF_CLK(ref_clk), .RESET(reset),
    .serial_select_n(link.serial_select_n), .sclk(link.sclk),
    .host_data_o(link.host_data_o), .host_data_oe(link.host_data_oe),
    .dev_data_o(link.dev_data_o), .dev_data_oe(link.dev_data_oe),
    .serial_data(link.serial_data));
  // ------------------------------
  // Clocks, wire sniffer, timeout
  // ------------------------------
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) synth_clk <= ~synth_clk;
  always @(posedge ref_clk) begin
    sclk_d <= link.sclk;
    sel_d  <= link.serial_select_n;
    if (link.serial_select_n && !sel_d)
      last_frame <= cap;
    if (!link.serial_select_n && sel_d)
      cap_idx <= 4'h0;
    else if (!link.serial_select_n && link.sclk && !sclk_d) begin
      cap[cap_idx] <= link.serial_data;
      cap_idx      <= cap_idx + 4'h1;
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge ref_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    r = prdata;
    slv_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Busy is polled, since a command sent while busy is dropped
  task automatic run_cmd(input logic dir, input logic [2:0] a,
                         input logic [10:0] d, output logic [10:0] rd);
    logic [31:0] r;
    apb(1'b1, 4'h0, {17'h0, dir, a, d}, r);
    do
      apb(1'b0, 4'h4, 32'h0, r);
    while (r[11] !== 1'b0);
    rd = r[10:0];
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [10:0] d);
    logic [10:0] rd;
    run_cmd(DIR_WRITE, a, d, rd);
    check({1'b0, last_frame}, {1'b0, d, a, DIR_WRITE});
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [10:0] exp);
    logic [10:0] rd;
    run_cmd(DIR_READ, a, 11'h0, rd);
    check({5'h0, rd}, {5'h0, exp});
    check({5'h0, last_frame[14:4]}, {5'h0, exp});
  endtask
  task automatic raw_frame(input logic [14:0] w, input int nb);
    @(posedge ref_clk);
    link_b.serial_select_n <= 1'b0;
    link_b.host_data_oe    <= 1'b1;
    for (int i = 0; i < nb; i++) begin
      link_b.host_data_o <= w[i];
      repeat (5) @(posedge ref_clk);
      link_b.sclk <= 1'b1;
      repeat (5) @(posedge ref_clk);
      link_b.sclk <= 1'b0;
    end
    link_b.host_data_oe <= 1'b0;
    repeat (5) @(posedge ref_clk);
    link_b.serial_select_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    link_b.sclk <= 1'b1;
    repeat (5) @(posedge ref_clk);
    link_b.sclk <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic conclude();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------
  // Sequence
  // ------------------------------
  initial begin
    ref_clk = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {synth_clk, aux_in, cap, last_frame, cap_idx, sclk_d} = '0;
    sel_d = 1'b1;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    link_b.serial_select_n = 1'b1;
    {link_b.sclk, link_b.host_data_o, link_b.host_data_oe} = 3'h0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    check({15'h0, ext_sel}, 16'h0);
    rd_reg(ROUTE_ADDR, ROUTE_RESET);
    apb(1'b0, 4'h8, 32'h0, q);
    check({15'h0, slv_err}, 16'h1);
    $display("Test defaults done");
    for (int i = 0; i < 2; i++) begin
      wr_reg(ROUTE_ADDR, tm[i]);
      repeat (4) @(posedge ref_clk);
      check({12'h0, aux}, {12'h0, tm[i][6:3]});
      check({14'h0, clk_p, clk_n}, {14'h0, tm[i][9], ~tm[i][9]});
    end
    $display("Test output test mode done");
    wr_reg(ROUTE_ADDR, 11'h000);
    for (int i = 0; i < 2; i++) begin
      aux_in <= pat[i];
      repeat (4) @(posedge ref_clk);
      check({12'h0, aux}, {12'h0, pat[i]});
    end
    $display("Test routing done");
    wr_reg(ROUTE_ADDR, 11'h078);
    n_hi = '0;
    repeat (8) begin
      @(posedge ref_clk);
      n_hi += 16'(aux[0]);
      check({14'h0, aux[0] ^ aux[2], aux[1] ^ aux[3]}, 16'h3);
    end
    check(n_hi, 16'h4);
    $display("Test divided phases done");
    wr_reg(ROUTE_ADDR, 11'h080);
    check({14'h0, clk_p, clk_n}, 16'h2);
    wr_reg(ROUTE_ADDR, 11'h000);
    check({14'h0, clk_p, clk_n}, 16'h2);
    aux_in <= 4'h1;
    tog = 1'b0;
    repeat (12) begin
      @(posedge ref_clk);
      if (clk_p === 1'b0)
        tog = 1'b1;
    end
    check({15'h0, tog}, 16'h1);
    $display("Test output hold done");
    wr_reg(ROUTE_ADDR, 11'h400);
    check({15'h0, ext_sel}, 16'h1);
    wr_reg(3'h3, 11'h7ff);
    rd_reg(ROUTE_ADDR, 11'h400);
    $display("Test reference select done");
    raw_frame({11'h400, ROUTE_ADDR, DIR_WRITE}, 15);
    check({15'h0, ext_sel_b}, 16'h1);
    raw_frame({11'h000, ROUTE_ADDR, DIR_WRITE}, 10);
    check({15'h0, ext_sel_b}, 16'h1);
    $display("Test short frame done");
    conclude();
  end
endmodule
